// ==== design/scr_pkg.sv ====
package scr_pkg;

  // Register indices of the byte-wide map; set 1 sits one index above set 0.
  localparam logic [4:0] IDX_FRAC_HI = 5'h00;
  localparam logic [4:0] IDX_FRAC_MID = 5'h02;
  localparam logic [4:0] IDX_FRAC_INT = 5'h04;
  localparam logic [4:0] IDX_INT_PRE = 5'h06;
  localparam logic [4:0] IDX_PRE_MID = 5'h08;
  localparam logic [4:0] IDX_PRE_LOW = 5'h0a;
  localparam logic [4:0] IDX_LOW_MID = 5'h0c;
  localparam logic [4:0] IDX_LOW_OUT = 5'h0e;
  localparam logic [4:0] IDX_OUT_LOOP = 5'h10;
  localparam logic [4:0] IDX_LOOP_TYPE = 5'h12;
  localparam logic [4:0] IDX_GLOBAL = 5'h14;
  localparam logic [4:0] IDX_REFCTL = 5'h15;
  localparam logic [4:0] IDX_FIXED = 5'h16;
  localparam logic [4:0] IDX_STATUS = 5'h17;
  localparam int STORED_REGS = 22;

  // Writable-bit masks; reserved positions are never stored and read as zero.
  localparam logic [7:0] MASK_LOOP_TYPE = 8'hfd;
  localparam logic [7:0] MASK_GLOBAL = 8'hfc;
  localparam logic [7:0] MASK_REFCTL = 8'hef;
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] FIXED_VALUE = 8'ha0;
  localparam logic [7:0] RESET_GLOBAL = 8'h0c;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Bit positions in the global control bytes.
  localparam int GB_MODE_HI = 7;
  localparam int GB_MODE_LO = 6;
  localparam int GB_SET_SEL = 5;
  localparam int GB_SRC_SEL = 4;
  localparam int GB_OE1 = 3;
  localparam int GB_OE0 = 2;
  localparam int RB_CHOICE = 7;
  localparam int RB_POL_HI = 6;
  localparam int RB_POL_LO = 5;
  localparam int RB_ADC_HI = 3;
  localparam int RB_ADC_LO = 2;
  localparam int RB_WIN_HI = 1;
  localparam int RB_WIN_LO = 0;

  // Bus address: fixed upper five bits, two low bits from the select pins.
  localparam logic [4:0] BUS_ADDR_FIXED = 5'h1b;

  // Timing.
  localparam int CLK_PERIOD_NS = 20;
  localparam int LOCK_WIN_BASE_US = 2;
  localparam int LOCK_WIN_BASE_CYC = (LOCK_WIN_BASE_US * 1000) / CLK_PERIOD_NS;
  localparam logic [4:0] ADC_DIV_MAX = 5'h10;

  typedef enum logic [1:0] {
    SCR_MODE_LOW_BW,
    SCR_MODE_SYNTH,
    SCR_MODE_HIGH_BW
  } scr_mode_e;

  typedef enum logic [1:0] {
    SCR_POL_PIN_MANUAL,
    SCR_POL_AUTO_NONREV,
    SCR_POL_AUTO_REV,
    SCR_POL_REG_MANUAL
  } scr_policy_e;

  typedef struct packed {
    logic output_type_select;
    logic [16:0] reference_predivider;
    logic [16:0] lower_loop_feedback_divider;
    logic [7:0] upper_feedback_integer;
    logic [17:0] upper_feedback_fraction;
    logic [10:0] output_divider;
    logic [6:0] loop_settings;
  } scr_cfg_s;

  typedef struct packed {
    logic active_reference_indicator;
    logic frozen_tracking_flag;
    logic reference1_fault;
    logic reference0_fault;
    logic crystal_fault;
    logic pll_locked_flag;
  } scr_status_s;

endpackage

// ==== design/scr_sync.sv ====
`timescale 1ns/1ps
module scr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // A change is accepted only once the second and third stage agree.
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          s1_reg[i] <= 1'b0;
          s2_reg[i] <= 1'b0;
          s3_reg[i] <= 1'b0;
          q_o[i] <= 1'b0;
        end else begin
          s1_reg[i] <= d_i[i];
          s2_reg[i] <= s1_reg[i];
          s3_reg[i] <= s2_reg[i];
          if (s2_reg[i] == s3_reg[i]) begin
            q_o[i] <= s3_reg[i];
          end
        end
      end
    end
  endgenerate

endmodule

// ==== design/scr_regs.sv ====
`timescale 1ns/1ps
module scr_regs
  import scr_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic address_select_low_i,
  input wire logic address_select_high_i,
  input wire logic config_pin_i,
  input wire logic output0_enable_pin_i,
  input wire logic output1_enable_pin_i,
  input wire logic reference_select_pin_i,
  input wire logic reference0_bad_i,
  input wire logic reference1_bad_i,
  input wire logic crystal_bad_i,
  input wire logic pll_locked_i,
  input wire logic frozen_tracking_i,
  input wire logic active_reference_i,
  output scr_cfg_s active_cfg_o,
  output logic active_set_o,
  output scr_mode_e pll_mode_o,
  output scr_policy_e reference_switch_policy_o,
  output logic reference_choice_o,
  output logic [4:0] adc_divide_o,
  output logic [9:0] lock_window_cycles_o,
  output logic differential_output_enable_o,
  output logic differential_output_lvds_o,
  output logic single_ended_output_enable_o,
  output scr_status_s status_pins_o
);

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_DEV,
    PH_PTR,
    PH_WR,
    PH_RD
  } scr_phase_e;

  typedef struct packed {
    logic [STORED_REGS-1:0][7:0] regs;
    scr_status_s status;
    scr_phase_e phase;
    logic [3:0] bit_cnt;
    logic ack_slot;
    logic [7:0] shift;
    logic [7:0] tx;
    logic [4:0] ptr;
    logic scl_q;
    logic sda_q;
    logic sda_oe;
    logic sda_out;
    scr_cfg_s cfg;
    logic set_sel;
    scr_mode_e mode;
    scr_policy_e policy;
    logic choice;
    logic [4:0] adc_div;
    logic [9:0] win_cyc;
    logic diff_en;
    logic diff_lvds;
    logic se_en;
  } scr_state_s;

  localparam int PIN_COUNT = 14;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Positions of the pins in the synchronised word; the status group sits lowest.
  localparam int PIN_LOCKED = 0;
  localparam int PIN_XTAL = 1;
  localparam int PIN_REF0 = 2;
  localparam int PIN_REF1 = 3;
  localparam int PIN_FROZEN = 4;
  localparam int PIN_ACTIVE = 5;
  localparam int PIN_REF_SEL = 6;
  localparam int PIN_OE1 = 7;
  localparam int PIN_OE0 = 8;
  localparam int PIN_CFG = 9;
  localparam int PIN_ADDR_LO = 10;
  localparam int PIN_ADDR_HI = 11;
  localparam int PIN_SDA = 12;
  localparam int PIN_SCL = 13;

  logic [PIN_COUNT-1:0] pins_raw;
  logic [PIN_COUNT-1:0] pins;
  scr_state_s state_reg;
  scr_state_s state_next;

  // Every pin passes the same synchroniser, so pin-driven fields share one latency, except cfg and diff_lvds, one and two cycles later.
  assign pins_raw[PIN_SCL] = scl_i;
  assign pins_raw[PIN_SDA] = sda_i;
  assign pins_raw[PIN_ADDR_HI] = address_select_high_i;
  assign pins_raw[PIN_ADDR_LO] = address_select_low_i;
  assign pins_raw[PIN_CFG] = config_pin_i;
  assign pins_raw[PIN_OE0] = output0_enable_pin_i;
  assign pins_raw[PIN_OE1] = output1_enable_pin_i;
  assign pins_raw[PIN_REF_SEL] = reference_select_pin_i;
  assign pins_raw[PIN_ACTIVE] = active_reference_i;
  assign pins_raw[PIN_FROZEN] = frozen_tracking_i;
  assign pins_raw[PIN_REF1] = reference1_bad_i;
  assign pins_raw[PIN_REF0] = reference0_bad_i;
  assign pins_raw[PIN_XTAL] = crystal_bad_i;
  assign pins_raw[PIN_LOCKED] = pll_locked_i;

  scr_sync #(
    .WIDTH(PIN_COUNT)
  ) u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .d_i(pins_raw),
    .q_o(pins)
  );

  // Gathers one configuration set from the byte map; set n sits at offset n.
  function automatic scr_cfg_s get_cfg(input logic [STORED_REGS-1:0][7:0] r,
                                       input logic n);
    scr_cfg_s c;
    logic [4:0] o;
    o = {4'h0, n};
    c.upper_feedback_fraction = {r[IDX_FRAC_HI + o], r[IDX_FRAC_MID + o],
                                 r[IDX_FRAC_INT + o][7:6]};
    c.upper_feedback_integer = {r[IDX_FRAC_INT + o][5:0], r[IDX_INT_PRE + o][7:6]};
    c.reference_predivider = {r[IDX_INT_PRE + o][5:0], r[IDX_PRE_MID + o],
                              r[IDX_PRE_LOW + o][7:5]};
    c.lower_loop_feedback_divider = {r[IDX_PRE_LOW + o][4:0], r[IDX_LOW_MID + o],
                                     r[IDX_LOW_OUT + o][7:4]};
    c.output_divider = {r[IDX_LOW_OUT + o][3:0], r[IDX_OUT_LOOP + o][7:1]};
    c.loop_settings = {r[IDX_OUT_LOOP + o][0], r[IDX_LOOP_TYPE + o][7:2]};
    c.output_type_select = r[IDX_LOOP_TYPE + o][0];
    return c;
  endfunction

  // Writable bits of a byte; reserved positions and read-only bytes give zero.
  function automatic logic [7:0] wr_mask(input logic [4:0] p);
    logic [7:0] m;
    m = MASK_FULL;
    if (p == IDX_LOOP_TYPE || p == IDX_LOOP_TYPE + 5'h01) begin
      m = MASK_LOOP_TYPE;
    end else if (p == IDX_GLOBAL) begin
      m = MASK_GLOBAL;
    end else if (p == IDX_REFCTL) begin
      m = MASK_REFCTL;
    end else if (p >= IDX_FIXED) begin
      m = RESET_BYTE;
    end
    return m;
  endfunction

  function automatic logic [7:0] rd_byte(input logic [STORED_REGS-1:0][7:0] r,
                                         input scr_status_s s,
                                         input logic [4:0] p);
    logic [7:0] b;
    b = RESET_BYTE;
    if (p < IDX_FIXED) begin
      b = r[p] & wr_mask(p);
    end else if (p == IDX_FIXED) begin
      b = FIXED_VALUE;
    end else if (p == IDX_STATUS) begin
      b = {s, 2'b00};
    end
    return b;
  endfunction

  always_comb begin
    logic scl;
    logic sda;
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic [7:0] rb;
    logic [7:0] gbl;
    logic [7:0] rctl;
    state_next = state_reg;
    scl = pins[PIN_SCL];
    sda = pins[PIN_SDA];
    rb = RESET_BYTE;
    gbl = state_reg.regs[IDX_GLOBAL];
    rctl = state_reg.regs[IDX_REFCTL];
    start = scl && state_reg.scl_q && state_reg.sda_q && !sda;
    stop = scl && state_reg.scl_q && !state_reg.sda_q && sda;
    rise = scl && !state_reg.scl_q;
    fall = !scl && state_reg.scl_q;
    state_next.scl_q = scl;
    state_next.sda_q = sda;

    // Flags follow the monitors and clear by themselves; host writes never reach them.
    state_next.status = pins[PIN_ACTIVE:PIN_LOCKED];

    if (start) begin
      state_next.phase = PH_DEV;
      state_next.bit_cnt = 4'h0;
      state_next.ack_slot = 1'b0;
      state_next.sda_oe = 1'b0;
    end else if (stop) begin
      state_next.phase = PH_IDLE;
      state_next.ack_slot = 1'b0;
      state_next.sda_oe = 1'b0;
    end else if (rise && state_reg.phase != PH_IDLE) begin
      if (state_reg.ack_slot) begin
        // A not-acknowledge from the host ends a block read.
        if (state_reg.phase == PH_RD && sda) begin
          state_next.phase = PH_IDLE;
        end
      end else begin
        state_next.shift = {state_reg.shift[6:0], sda};
        state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
      end
    end else if (fall && state_reg.phase != PH_IDLE) begin
      if (state_reg.ack_slot) begin
        state_next.ack_slot = 1'b0;
        state_next.bit_cnt = 4'h0;
        state_next.sda_oe = 1'b0;
        if (state_reg.phase == PH_RD) begin
          rb = rd_byte(state_reg.regs, state_reg.status, state_reg.ptr);
          state_next.sda_oe = !rb[7];
          state_next.tx = {rb[6:0], 1'b0};
        end
      end else if (state_reg.bit_cnt == BITS_PER_BYTE) begin
        state_next.ack_slot = 1'b1;
        state_next.sda_oe = 1'b1;
        case (state_reg.phase)
          PH_DEV: begin
            if (state_reg.shift[7:1] == {BUS_ADDR_FIXED, pins[PIN_ADDR_HI],
                                         pins[PIN_ADDR_LO]}) begin
              state_next.phase = state_reg.shift[0] ? PH_RD : PH_PTR;
            end else begin
              state_next.phase = PH_IDLE;
              state_next.ack_slot = 1'b0;
              state_next.sda_oe = 1'b0;
            end
          end
          PH_PTR: begin
            state_next.ptr = state_reg.shift[4:0];
            state_next.phase = PH_WR;
          end
          PH_WR: begin
            // Reserved positions are masked, so a careless host cannot set them.
            // The pointer wraps at five bits; bytes past the map are dropped but acked.
            if (state_reg.ptr < IDX_FIXED) begin
              state_next.regs[state_reg.ptr] = state_reg.shift & wr_mask(state_reg.ptr);
            end
            state_next.ptr = state_reg.ptr + 5'h01;
          end
          PH_RD: begin
            state_next.sda_oe = 1'b0;
            state_next.ptr = state_reg.ptr + 5'h01;
          end
          default: begin
            state_next.phase = PH_IDLE;
            state_next.ack_slot = 1'b0;
            state_next.sda_oe = 1'b0;
          end
        endcase
      end else if (state_reg.phase == PH_RD) begin
        state_next.sda_oe = !state_reg.tx[7];
        state_next.tx = {state_reg.tx[6:0], 1'b0};
      end
    end

    // Applied settings; they lag the register bytes by one cycle, except cfg (up to two) and diff_lvds (up to three).
    state_next.set_sel = gbl[GB_SRC_SEL] ? gbl[GB_SET_SEL] : pins[PIN_CFG];
    state_next.cfg = get_cfg(state_reg.regs, state_reg.set_sel);
    case (gbl[GB_MODE_HI:GB_MODE_LO])
      2'b00: state_next.mode = SCR_MODE_LOW_BW;
      2'b01: state_next.mode = SCR_MODE_SYNTH;
      default: state_next.mode = SCR_MODE_HIGH_BW;
    endcase
    state_next.policy = scr_policy_e'(rctl[RB_POL_HI:RB_POL_LO]);
    // In pin-manual mode the register choice is ignored and the pin picks the input.
    state_next.choice = (state_next.policy == SCR_POL_PIN_MANUAL) ? pins[PIN_REF_SEL] :
                        rctl[RB_CHOICE];
    state_next.adc_div = ADC_DIV_MAX >> rctl[RB_ADC_HI:RB_ADC_LO];
    state_next.win_cyc = 10'(LOCK_WIN_BASE_CYC) << rctl[RB_WIN_HI:RB_WIN_LO];
    state_next.diff_en = gbl[GB_OE0] && pins[PIN_OE0];
    state_next.se_en = gbl[GB_OE1] && pins[PIN_OE1];
    state_next.diff_lvds = state_reg.cfg.output_type_select;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= '0;
      state_reg.regs[IDX_GLOBAL] <= RESET_GLOBAL;
      // The synchroniser leaves reset low, so the first bus edges seen are ignored in idle.
      state_reg.scl_q <= 1'b1;
      state_reg.sda_q <= 1'b1;
      state_reg.phase <= PH_IDLE;
      state_reg.mode <= SCR_MODE_LOW_BW;
      state_reg.policy <= SCR_POL_PIN_MANUAL;
      state_reg.adc_div <= ADC_DIV_MAX;
      state_reg.win_cyc <= 10'(LOCK_WIN_BASE_CYC);
    end else begin
      state_reg <= state_next;
    end
  end

  // The data pin is open drain: only its enable moves, the driven level stays low.
  assign sda_o = state_reg.sda_out;
  assign sda_oe_o = state_reg.sda_oe;
  assign active_cfg_o = state_reg.cfg;
  assign active_set_o = state_reg.set_sel;
  assign pll_mode_o = state_reg.mode;
  assign reference_switch_policy_o = state_reg.policy;
  assign reference_choice_o = state_reg.choice;
  assign adc_divide_o = state_reg.adc_div;
  assign lock_window_cycles_o = state_reg.win_cyc;
  assign differential_output_enable_o = state_reg.diff_en;
  assign differential_output_lvds_o = state_reg.diff_lvds;
  assign single_ended_output_enable_o = state_reg.se_en;
  assign status_pins_o = state_reg.status;

endmodule

// ==== tb/scr_regs_monitor.sv ====
`timescale 1ns/1ps
module scr_regs_monitor
  import scr_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic output0_enable_pin_i,
  input wire logic output1_enable_pin_i,
  input wire logic reference0_bad_i,
  input wire logic crystal_bad_i,
  input wire logic pll_locked_i,
  input wire logic frozen_tracking_i,
  input wire logic active_reference_i,
  input wire logic [4:0] adc_divide_o,
  input wire logic [9:0] lock_window_cycles_o,
  input wire logic differential_output_enable_o,
  input wire logic single_ended_output_enable_o,
  input wire scr_status_s status_pins_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Eight quiet cycles cover the pin synchroniser and its agree filter.
  sequence s_oe0_low;
    !output0_enable_pin_i [*8];
  endsequence
  sequence s_oe1_low;
    !output1_enable_pin_i [*8];
  endsequence
  AST_DIFF_OFF: assert property (s_oe0_low |=> !differential_output_enable_o)
    else $error("differential pair driven while its enable pin is low");
  AST_SE_OFF: assert property (s_oe1_low |=> !single_ended_output_enable_o)
    else $error("single ended output on while its enable pin is low");
  AST_LOCK: assert property (pll_locked_i [*8] |=> status_pins_o.pll_locked_flag)
    else $error("lock pin does not follow lock");
  AST_XTAL_CLR: assert property (!crystal_bad_i [*8] |=> !status_pins_o.crystal_fault)
    else $error("crystal fault did not clear");
  AST_REF0: assert property (reference0_bad_i [*8] |=> status_pins_o.reference0_fault)
    else $error("reference fault not shown");
  AST_FROZEN: assert property (!frozen_tracking_i [*8] |=> !status_pins_o.frozen_tracking_flag)
    else $error("frozen_tracking_flag shown while tracking");
  AST_ACTIVE: assert property (active_reference_i [*8] |=> status_pins_o.active_reference_indicator)
    else $error("active reference not shown");
  AST_ADC: assert property (adc_divide_o inside {5'h10, 5'h08, 5'h04, 5'h02})
    else $error("adc divide out of range");
  AST_WIN: assert property (lock_window_cycles_o inside {10'h064, 10'h0c8, 10'h190, 10'h320})
    else $error("lock window out of range");
  AST_SDA_LOW: assert property (sda_oe_o |-> !sda_o)
    else $error("data pin driven high");
endmodule
bind scr_regs scr_regs_monitor u_mon (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .output0_enable_pin_i(output0_enable_pin_i), .output1_enable_pin_i(output1_enable_pin_i),
  .reference0_bad_i(reference0_bad_i), .crystal_bad_i(crystal_bad_i),
  .pll_locked_i(pll_locked_i), .frozen_tracking_i(frozen_tracking_i),
  .active_reference_i(active_reference_i), .adc_divide_o(adc_divide_o),
  .lock_window_cycles_o(lock_window_cycles_o),
  .differential_output_enable_o(differential_output_enable_o),
  .single_ended_output_enable_o(single_ended_output_enable_o), .status_pins_o(status_pins_o));

// ==== tb/scr_i2c_host.sv ====
`timescale 1ns/1ps
module scr_i2c_host (
  input wire logic clk_i,
  input wire logic sda_wire_i,
  output logic scl_o,
  output logic sda_o
);
  // Five clocks a phase stays above the two-clock minimum of the receiver.
  task automatic hold();
    repeat (5) @(posedge clk_i);
  endtask
  task automatic start();
    sda_o <= 1'b1;
    hold();
    scl_o <= 1'b1;
    hold();
    sda_o <= 1'b0;
    hold();
    scl_o <= 1'b0;
    hold();
  endtask
  task automatic stop();
    sda_o <= 1'b0;
    hold();
    scl_o <= 1'b1;
    hold();
    sda_o <= 1'b1;
    hold();
  endtask
  // Data only moves while the clock is low, so no false start or stop is made.
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                      output logic ack_out);
    logic [8:0] w;
    w = {d, ack_in};
    for (int i = 8; i >= 0; i--) begin
      sda_o <= w[i];
      hold();
      scl_o <= 1'b1;
      hold();
      w[i] = sda_wire_i;
      scl_o <= 1'b0;
      hold();
    end
    {q, ack_out} = w;
  endtask
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
endmodule

// ==== tb/test_scr_regs.sv ====
`timescale 1ns/1ps
module test_scr_regs;
  import scr_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic scl, hsda, sda_oe, sa0, sa1, cfg_pin, oe0_pin, oe1_pin, ref_pin, aset, choice;
  logic den, lvds, sen, ha;
  logic [5:0] st;
  logic [7:0] hq;
  logic [7:0] mem [0:23];
  logic [31:0] x = 32'hec92;
  logic [95:0] seen;
  logic [95:0] exp_q[$];
  event res;
  int mismatches = 0;
  int compares = 0;
  scr_cfg_s cfg;
  scr_mode_e mode;
  scr_policy_e pol;
  logic [4:0] adc;
  logic [9:0] win;
  scr_status_s stp;
  // The data wire has a pull-up: high unless the host or the device pulls it low.
  wire sda_w = hsda & ~sda_oe;
  scr_regs u_dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .scl_i(scl), .sda_i(sda_w), .sda_o(),
    .sda_oe_o(sda_oe), .address_select_low_i(sa0), .address_select_high_i(sa1),
    .config_pin_i(cfg_pin), .output0_enable_pin_i(oe0_pin), .output1_enable_pin_i(oe1_pin),
    .reference_select_pin_i(ref_pin), .reference0_bad_i(st[2]), .reference1_bad_i(st[3]),
    .crystal_bad_i(st[1]), .pll_locked_i(st[0]), .frozen_tracking_i(st[4]),
    .active_reference_i(st[5]), .active_cfg_o(cfg), .active_set_o(aset), .pll_mode_o(mode),
    .reference_switch_policy_o(pol), .reference_choice_o(choice), .adc_divide_o(adc),
    .lock_window_cycles_o(win), .differential_output_enable_o(den),
    .differential_output_lvds_o(lvds), .single_ended_output_enable_o(sen), .status_pins_o(stp)
  );
  scr_i2c_host u_host (.clk_i(clk_i), .sda_wire_i(sda_w), .scl_o(scl), .sda_o(hsda));
  always #10 clk_i = ~clk_i;
  function automatic logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  task automatic chk(input logic [95:0] s, input logic [95:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic note(input logic [95:0] s, input logic [95:0] e);
    exp_q.push_back(e);
    seen = s;
    ->res;
    @(posedge clk_i);
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Set s bytes sit at the odd or even indices; the fields are cut from their concatenation.
  function automatic scr_cfg_s exp_cfg(input logic s);
    logic [79:0] c;
    for (int k = 0; k < 10; k++) c[79-8*k -: 8] = mem[2*k+int'(s)];
    return {c[0], c[53:37], c[36:20], c[61:54], c[79:62], c[19:9], c[8:2]};
  endfunction
  task automatic wr(input int p, input int n);
    u_host.start();
    u_host.xfer({BUS_ADDR_FIXED, sa1, sa0, 1'b0}, 1'b1, hq, ha);
    note(96'(ha), 96'h0);
    u_host.xfer(8'(p), 1'b1, hq, ha);
    for (int k = p; k < p + n; k++)
      u_host.xfer(mem[k], 1'b1, hq, ha);
    u_host.stop();
  endtask
  task automatic rd(input int p, input int n);
    u_host.start();
    u_host.xfer({BUS_ADDR_FIXED, sa1, sa0, 1'b0}, 1'b1, hq, ha);
    u_host.xfer(8'(p), 1'b1, hq, ha);
    u_host.start();
    u_host.xfer({BUS_ADDR_FIXED, sa1, sa0, 1'b1}, 1'b1, hq, ha);
    for (int k = p; k < p + n; k++) begin
      u_host.xfer(8'hff, k == p + n - 1, hq, ha);
      note(96'(hq), 96'(mem[k]));
    end
    u_host.stop();
  endtask
  initial forever begin
    @res;
    chk(seen, exp_q.pop_front());
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    mismatches++;
    conclude();
  end
  initial begin
    logic [31:0] r;
    logic [1:0] s;
    logic [3:0] b;
    logic e;
    {sa1, sa0, cfg_pin, oe0_pin, oe1_pin, ref_pin} = 6'(rnd());
    st = 6'(rnd());
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    for (int k = 0; k < 24; k++)
      mem[k] = 8'h00;
    mem[20] = 8'h0c;
    mem[22] = 8'ha0;
    mem[23] = {st, 2'b00};
    rd(0, 24);
    $display("reset values done");
    for (int k = 0; k < 20; k++)
      mem[k] = (k > 17) ? (8'(rnd()) & 8'hfd) : 8'(rnd());
    mem[20] = 8'h1c;
    wr(0, 21);
    rd(0, 24);
    for (int k = 0; k < 4; k++) begin
      s = 2'(k);
      mem[20] = {2'b00, s[0], ~s[1], 4'hc};
      cfg_pin <= ~s[0];
      e = s[1] ? ~s[0] : s[0];
      wr(20, 1);
      repeat (8) @(posedge clk_i);
      note(96'({aset, lvds, cfg}), 96'({e, exp_cfg(e).output_type_select, exp_cfg(e)}));
    end
    $display("config sets done");
    for (int i = 0; i < 16; i++) begin
      b = 4'(i);
      r = rnd();
      oe0_pin <= r[0];
      oe1_pin <= r[1];
      ref_pin <= r[2];
      mem[20] = {b[1:0], 2'b01, b[3:2], 2'b00};
      mem[21] = {r[3], b[1:0], 1'b0, b[1:0], b[1:0]};
      wr(20, 2);
      repeat (8) @(posedge clk_i);
      note(96'({mode, pol, choice, adc, win, den, sen}),
           96'({b[1:0] == 2'b00 ? SCR_MODE_LOW_BW : (b[1:0] == 2'b01 ? SCR_MODE_SYNTH :
           SCR_MODE_HIGH_BW), b[1:0], b[1:0] == 2'b00 ? ref_pin : r[3], 5'h10 >> b[1:0],
           10'h064 << b[1:0], b[2] & oe0_pin, b[3] & oe1_pin}));
    end
    $display("global controls done");
    for (int k = 0; k < 3; k++) begin
      st <= 6'(rnd());
      repeat (8) @(posedge clk_i);
      note(96'(stp), 96'(st));
      mem[22] = 8'h5f;
      mem[23] = 8'hfc;
      wr(22, 2);
      mem[22] = 8'ha0;
      mem[23] = {st, 2'b00};
      rd(20, 4);
    end
    $display("status done");
    u_host.start();
    u_host.xfer({BUS_ADDR_FIXED, ~sa1, sa0, 1'b0}, 1'b1, hq, ha);
    note(96'(ha), 96'h1);
    u_host.stop();
    $display("address done");
    conclude();
  end
endmodule
